/* File: hw/sapc_pkg.sv */
// Purpose: shared constants and types for the converter control ends
// Assumes: clk at 250 MHz
// Notes: timing figures in ns, cycle counts derived
package sapc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DATA_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int BUSY_RISE_DELAY_NS = 8;
  localparam int CONVERSION_TIME_NS = 200;
  localparam int RESET_PHASE_WIDTH_NS = 40;
  localparam int POWERDOWN_ENTRY_WIDTH_NS = 400;
  localparam int POWERDOWN_EXIT_DELAY_NS = 400;
  localparam int ABORT_LIMIT_NS = 45;
  localparam int BUSY_RISE_CYC = (BUSY_RISE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = CONVERSION_TIME_NS / CLK_PERIOD_NS;
  localparam int RESET_PHASE_CYC = (RESET_PHASE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PD_ENTRY_CYC = (POWERDOWN_ENTRY_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PD_EXIT_CYC = POWERDOWN_EXIT_DELAY_NS / CLK_PERIOD_NS;
  localparam int INIT_CONVERSIONS = 4;
  localparam int CNT_W = 8;
  localparam logic [DATA_W-1:0] CODE_ABORT = 12'hFE0;
  localparam logic [DATA_W-1:0] CODE_ZERO = 12'h000;
  localparam int BYTE_LOW_W = 4;
  localparam int HOST_ACQ_CYC = 20;
  localparam int HOST_NAP_EXTRA_NS = 60;
  localparam int HOST_NAP_EXTRA_CYC = (HOST_NAP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_RD_CYC = 2;
  typedef enum logic [2:0] {SAPC_IDLE, SAPC_DELAY, SAPC_CONV, SAPC_RESET, SAPC_PDOWN, SAPC_EXIT} sapc_state_t;
  function automatic logic [CNT_W-1:0] sapc_cnt(input int v);
    return CNT_W'(v);
  endfunction
endpackage

/* File: hw/sapc_if.sv */
// Purpose: parallel bus between converter control and host
// Assumes: data bus resolved here from output enable
// Notes: one modport per party
interface sapc_if;
  logic chip_select_n;
  logic convert_strobe_n;
  logic read_strobe_n;
  logic byte_select;
  logic nap_request_n;
  logic powerdown_reset_n;
  logic busy;
  logic [11:0] output_data_pins;
  logic data_oe;
  logic [11:0] bus_data;
  assign bus_data = data_oe ? output_data_pins : 12'hFFF;
  modport device (input chip_select_n, convert_strobe_n, read_strobe_n, byte_select, nap_request_n,
    powerdown_reset_n, output busy, output_data_pins, data_oe);
  modport host (output chip_select_n, convert_strobe_n, read_strobe_n, byte_select, nap_request_n,
    powerdown_reset_n, input busy, input bus_data, input data_oe);
endinterface

/* File: hw/sapc_fifo.sv */
// Purpose: parameterised valid/ready fifo
// Assumes: single clock
// Notes: depth power of two
module sapc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sapc_fifo

/* File: hw/sapc_device.sv */
// Purpose: converter control end: start, abort, readout, nap, powerdown/reset
// Assumes: host pins pass a three-flop synchroniser
// Notes: sample_value stands in for the comparator result
// Overview of operation
// - conversion starts on strobe or select fall
// - select fall during busy, strobe high aborts
// - aborted conversion reads back code FE0
// - drive data only while select, read low
// - bus released whenever select or read high
// - byte select low gives full word
// - byte select high gives low nibble on top
// - results are unsigned straight binary
// - host uses back-to-back above 3.5 MSPS
// - busy rises after busy-rise delay
// - conversion completes within conversion time
// - strobe high long enough allows early acquisition
// - host avoids abort condition in back-to-back
// - nap request low naps after busy falls
// - host lengthens acquisition after nap by 60ns
// - nap held while request low, idle, unsampled
// - powerdown/reset acts on the clock, through the synchroniser
// - reset phase outputs code FE0
// - long powerdown/reset low enters powerdown
// - first four conversions flagged invalid
// - reset aborts conversion, short reset resumes
// - ready after powerdown-exit delay
module sapc_device (
  input wire logic clk,
  input wire logic rst,
  sapc_if.device pins,
  input wire logic [sapc_pkg::DATA_W-1:0] sample_value,
  output logic napping,
  output logic powered_down,
  output logic result_valid
);
  import sapc_pkg::*;
  logic [2:0] cs_s;
  logic [2:0] cv_s;
  logic [2:0] rd_s;
  logic [2:0] by_s;
  logic [2:0] np_s;
  logic [2:0] pr_s;
  logic cs_l;
  logic cv_l;
  logic rd_l;
  logic by_l;
  logic np_l;
  logic pr_l;
  logic cs_fall;
  logic cv_fall;
  logic start;
  logic abort;
  sapc_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [DATA_W-1:0] result;
  logic [2:0] init_cnt;
  logic sampled;
  // three-flop synchronisers, level accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s <= 3'h7;
      cv_s <= 3'h7;
      rd_s <= 3'h7;
      by_s <= 3'h0;
      np_s <= 3'h7;
      pr_s <= 3'h0;
    end else begin
      cs_s <= {cs_s[1:0], pins.chip_select_n};
      cv_s <= {cv_s[1:0], pins.convert_strobe_n};
      rd_s <= {rd_s[1:0], pins.read_strobe_n};
      by_s <= {by_s[1:0], pins.byte_select};
      np_s <= {np_s[1:0], pins.nap_request_n};
      pr_s <= {pr_s[1:0], pins.powerdown_reset_n};
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_l <= 1'b1;
      cv_l <= 1'b1;
      rd_l <= 1'b1;
      by_l <= 1'b0;
      np_l <= 1'b1;
      pr_l <= 1'b0;
    end else begin
      if (cs_s[1] == cs_s[2]) cs_l <= cs_s[2];
      if (cv_s[1] == cv_s[2]) cv_l <= cv_s[2];
      if (rd_s[1] == rd_s[2]) rd_l <= rd_s[2];
      if (by_s[1] == by_s[2]) by_l <= by_s[2];
      if (np_s[1] == np_s[2]) np_l <= np_s[2];
      if (pr_s[1] == pr_s[2]) pr_l <= pr_s[2];
    end
  end
  assign cs_fall = cs_l && cs_s[1] == cs_s[2] && !cs_s[2];
  assign cv_fall = cv_l && cv_s[1] == cv_s[2] && !cv_s[2];
  assign start = (cv_fall && !cs_l) || (cs_fall && !cv_l);
  assign abort = cs_fall && cv_l && pins.busy;
  // conversion, reset and powerdown sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SAPC_RESET;
      cnt <= '0;
      result <= CODE_ABORT;
    end else if (!pr_l && state != SAPC_RESET && state != SAPC_PDOWN) begin
      state <= SAPC_RESET;
      cnt <= '0;
      result <= CODE_ABORT;
    end else begin
      unique case (state)
        SAPC_IDLE: begin
          if (start) begin
            state <= SAPC_DELAY;
            cnt <= '0;
          end
        end
        SAPC_DELAY: begin
          cnt <= cnt + 1'b1;
          if (cnt == sapc_cnt(BUSY_RISE_CYC - 1)) begin
            state <= SAPC_CONV;
            cnt <= '0;
          end
        end
        SAPC_CONV: begin
          cnt <= cnt + 1'b1;
          if (abort) begin
            state <= SAPC_IDLE;
            result <= CODE_ABORT;
          end else if (cnt == sapc_cnt(CONV_CYC - BUSY_RISE_CYC - 1)) begin
            state <= SAPC_IDLE;
            result <= sample_value;
          end
        end
        SAPC_RESET: begin
          if (pr_l) begin
            state <= SAPC_IDLE;
          end else if (cnt == sapc_cnt(PD_ENTRY_CYC)) begin
            state <= SAPC_PDOWN;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        SAPC_PDOWN: begin
          if (pr_l) begin
            state <= SAPC_EXIT;
            cnt <= '0;
          end
        end
        SAPC_EXIT: begin
          cnt <= cnt + 1'b1;
          if (!pr_l) begin
            state <= SAPC_RESET;
            cnt <= '0;
          end else if (cnt == sapc_cnt(PD_EXIT_CYC - 1)) begin
            state <= SAPC_IDLE;
          end
        end
      endcase
    end
  end
  // first conversions after reset are initialisation only
  always_ff @(posedge clk) begin
    if (rst || state == SAPC_RESET) begin
      init_cnt <= '0;
      result_valid <= 1'b0;
    end else if (state == SAPC_CONV && cnt == sapc_cnt(CONV_CYC - BUSY_RISE_CYC - 1) && !abort) begin
      if (init_cnt == 3'(INIT_CONVERSIONS)) begin
        result_valid <= 1'b1;
      end else begin
        init_cnt <= init_cnt + 1'b1;
        result_valid <= 1'b0;
      end
    end
  end
  // nap tracking: sampling begins on strobe rise or select fall with strobe high
  always_ff @(posedge clk) begin
    if (rst) begin
      sampled <= 1'b0;
      napping <= 1'b0;
    end else begin
      if (state == SAPC_IDLE && ((cv_s[1] == cv_s[2] && cv_s[2] && !cv_l) || (cs_fall && cv_l))) begin
        sampled <= 1'b1;
      end else if (state != SAPC_IDLE) begin
        sampled <= 1'b0;
      end
      napping <= state == SAPC_IDLE && !np_l && !sampled && !start;
    end
  end
  assign pins.busy = state == SAPC_CONV;
  assign powered_down = state == SAPC_PDOWN;
  assign pins.data_oe = !cs_l && !rd_l;
  assign pins.output_data_pins = (state == SAPC_RESET) ? CODE_ABORT :
    by_l ? {result[BYTE_LOW_W-1:0], 8'h00} : result;
endmodule // sapc_device

/* File: hw/sapc_host.sv */
// Purpose: host end: drives conversions, reads words into a fifo
// Assumes: device end on the same clock
// Notes: four results after reset are dropped
module sapc_host (
  input wire logic clk,
  input wire logic rst,
  sapc_if.host pins,
  input wire logic go,
  input wire logic nap_en,
  input wire logic byte_mode,
  output logic [sapc_pkg::DATA_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import sapc_pkg::*;
  typedef enum logic [2:0] {SH_ACQ, SH_CONV, SH_WAIT, SH_RD_HI, SH_RD_LO, SH_PUSH} sh_state_t;
  sh_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [DATA_W-1:0] word;
  logic [2:0] drop;
  logic napped;
  logic push_ready;
  logic push_valid;
  assign push_valid = state == SH_PUSH && drop == 3'(INIT_CONVERSIONS);
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SH_ACQ;
      cnt <= '0;
      word <= '0;
      drop <= '0;
      napped <= 1'b1;
      pins.chip_select_n <= 1'b0;
      pins.convert_strobe_n <= 1'b1;
      pins.read_strobe_n <= 1'b1;
      pins.byte_select <= 1'b0;
      pins.powerdown_reset_n <= 1'b1;
    end else begin
      unique case (state)
        SH_ACQ: begin
          cnt <= cnt + 1'b1;
          if (go && cnt >= sapc_cnt(HOST_ACQ_CYC + (napped ? HOST_NAP_EXTRA_CYC : 0))) begin
            pins.convert_strobe_n <= 1'b0;
            state <= SH_CONV;
            cnt <= '0;
          end
        end
        SH_CONV: begin
          cnt <= cnt + 1'b1;
          if (pins.busy) begin
            state <= SH_WAIT;
          end
        end
        SH_WAIT: begin
          if (!pins.busy) begin
            pins.convert_strobe_n <= 1'b1;
            pins.read_strobe_n <= 1'b0;
            pins.byte_select <= 1'b0;
            napped <= nap_en;
            state <= SH_RD_HI;
            cnt <= '0;
          end
        end
        SH_RD_HI: begin
          cnt <= cnt + 1'b1;
          if (cnt == sapc_cnt(HOST_RD_CYC + 4)) begin
            word <= pins.bus_data;
            cnt <= '0;
            if (byte_mode) begin
              pins.byte_select <= 1'b1;
              state <= SH_RD_LO;
            end else begin
              pins.read_strobe_n <= 1'b1;
              state <= SH_PUSH;
            end
          end
        end
        SH_RD_LO: begin
          cnt <= cnt + 1'b1;
          if (cnt == sapc_cnt(HOST_RD_CYC + 4)) begin
            word <= {word[DATA_W-1:4], pins.bus_data[DATA_W-1:DATA_W-BYTE_LOW_W]};
            pins.read_strobe_n <= 1'b1;
            pins.byte_select <= 1'b0;
            state <= SH_PUSH;
          end
        end
        SH_PUSH: begin
          if (drop != 3'(INIT_CONVERSIONS)) begin
            drop <= drop + 1'b1;
            state <= SH_ACQ;
            cnt <= '0;
          end else if (push_ready) begin
            state <= SH_ACQ;
            cnt <= '0;
          end
        end
      endcase
    end
  end
  assign pins.nap_request_n = !nap_en;
  sapc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule // sapc_host

/* File: tb/sapc_assertions.sv */
// Purpose: wire checks on the bus joining host and device ends
// Assumes: one clock, sync reset
// Notes: device pin filter adds up to four cycles
module sapc_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic convert_strobe_n,
  input wire logic read_strobe_n,
  input wire logic byte_select,
  input wire logic powerdown_reset_n,
  input wire logic busy,
  input wire logic [11:0] output_data_pins,
  input wire logic data_oe
);
  import sapc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [CNT_W-1:0] busy_cnt;
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end
  sequence s_start;
    $fell(convert_strobe_n) && !chip_select_n && !busy && powerdown_reset_n;
  endsequence
  sequence s_abort;
    $fell(chip_select_n) && busy && convert_strobe_n;
  endsequence
  AST_START: assert property (s_start |-> ##[1:8] busy)
    else $error("busy late after start");
  AST_BUSY_HOLD: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  AST_CONV_TIME: assert property (busy_cnt < CONV_CYC)
    else $error("conversion too long");
  AST_NO_ABORT: assert property (not s_abort)
    else $error("host made abort condition");
  AST_DRIVE: assert property ((!chip_select_n && !read_strobe_n)[*5] |-> data_oe)
    else $error("bus not driven on read");
  AST_RELEASE: assert property ((chip_select_n || read_strobe_n)[*5] |-> !data_oe)
    else $error("bus driven outside read");
  AST_LOW_BYTE: assert property (byte_select[*5] ##0 data_oe |-> output_data_pins[7:0] == 8'h00)
    else $error("low byte lanes not zero");
  AST_RESET_CODE: assert property ((!powerdown_reset_n && !byte_select)[*6] ##0 data_oe
    |-> output_data_pins == CODE_ABORT)
    else $error("reset code wrong");
  AST_RESET_ABORT: assert property ($fell(powerdown_reset_n) |-> ##[0:11] !busy)
    else $error("reset did not stop conversion");
endmodule // sapc_assertions

/* File: tb/tb.sv */
// Purpose: bench for the joined ends and a bench-driven device end
// Assumes: clk 250 MHz, rst high 16 cycles
// Notes: second bus reaches abort, reset and powerdown
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sapc_pkg::*;
  typedef struct packed {logic [11:0] s; logic m; logic [11:0] e;} sapc_row_t;
  sapc_row_t rows [4] = '{'{12'hFFF, 1'b0, 12'hFFF}, '{12'h800, 1'b1, 12'h800},
    '{12'h7FF, 1'b0, 12'h7FF}, '{12'h000, 1'b1, 12'h000}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic nap_en = 1'b0;
  logic byte_mode = 1'b0;
  logic out_ready = 1'b0;
  logic saw_nap = 1'b0;
  logic [11:0] sample_value = 12'h000;
  logic [11:0] sample_b = 12'h000;
  logic [11:0] out_data;
  logic [11:0] w;
  logic out_valid, napping, powered_down, result_valid, nap_b, pd_b, valid_b;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int k;
  sapc_if bus_a();
  sapc_if bus_b();
  sapc_device i_sapc_device (.clk(clk), .rst(rst), .pins(bus_a), .sample_value(sample_value),
    .napping(napping), .powered_down(powered_down), .result_valid(result_valid));
  sapc_host i_sapc_host (.clk(clk), .rst(rst), .pins(bus_a), .go(go), .nap_en(nap_en),
    .byte_mode(byte_mode), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
  sapc_device i_sapc_device_b (.clk(clk), .rst(rst), .pins(bus_b), .sample_value(sample_b),
    .napping(nap_b), .powered_down(pd_b), .result_valid(valid_b));
  sapc_assertions i_sapc_assertions (.clk(clk), .rst(rst), .chip_select_n(bus_a.chip_select_n),
    .convert_strobe_n(bus_a.convert_strobe_n), .read_strobe_n(bus_a.read_strobe_n),
    .byte_select(bus_a.byte_select), .powerdown_reset_n(bus_a.powerdown_reset_n), .busy(bus_a.busy),
    .output_data_pins(bus_a.output_data_pins), .data_oe(bus_a.data_oe));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (napping === 1'b1) saw_nap <= 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic get_word();
    n = 0;
    while (out_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    w = out_data;
    @(posedge clk);
    out_ready <= 1'b1;
    @(posedge clk);
    out_ready <= 1'b0;
  endtask
  task automatic wait_b(input logic lvl, input int lim);
    n = 0;
    while (bus_b.busy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic conv_b();
    @(posedge clk);
    bus_b.chip_select_n <= 1'b0;
    bus_b.convert_strobe_n <= 1'b0;
    wait_b(1'b1, 10);
    check(12'(n < 10), 12'h001);
    wait_b(1'b0, CONV_CYC);
    check(12'(n < CONV_CYC), 12'h001);
    @(posedge clk);
    bus_b.convert_strobe_n <= 1'b1;
    tick(HOST_ACQ_CYC);
  endtask
  task automatic rd_b(input logic bs, input logic [11:0] exp);
    @(posedge clk);
    bus_b.read_strobe_n <= 1'b0;
    bus_b.byte_select <= bs;
    tick(6);
    @(negedge clk);
    check(bus_b.bus_data, exp);
    @(posedge clk);
    bus_b.read_strobe_n <= 1'b1;
    tick(6);
    @(negedge clk);
    check(bus_b.bus_data, 12'hFFF);
  endtask
  initial begin
    bus_b.chip_select_n = 1'b0;
    bus_b.convert_strobe_n = 1'b1;
    bus_b.read_strobe_n = 1'b1;
    bus_b.byte_select = 1'b0;
    bus_b.nap_request_n = 1'b1;
    bus_b.powerdown_reset_n = 1'b1;
    tick(16);
    rst <= 1'b0;
    tick(8);
    go <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      sample_value <= rows[i].s;
      byte_mode <= rows[i].m;
      out_ready <= 1'b1;
      tick(200);
      out_ready <= 1'b0;
      get_word();
      check(w, rows[i].e);
    end
    tick(FIFO_DEPTH * 100);
    go <= 1'b0;
    k = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (out_valid === 1'b1) begin
        get_word();
        k++;
        check(w, rows[3].e);
      end
    end
    check(12'(k >= FIFO_DEPTH && k <= FIFO_DEPTH + 2), 12'h001);
    @(posedge clk);
    nap_en <= 1'b1;
    go <= 1'b1;
    out_ready <= 1'b1;
    tick(400);
    out_ready <= 1'b0;
    get_word();
    check(w, rows[3].e);
    check(12'(saw_nap), 12'h001);
    go <= 1'b0;
    nap_en <= 1'b0;
    for (int i = 0; i < INIT_CONVERSIONS; i++) begin
      check(12'(valid_b), 12'h000);
      conv_b();
    end
    check(12'(valid_b), 12'h000);
    sample_b <= 12'h5A3;
    conv_b();
    check(12'(valid_b), 12'h001);
    rd_b(1'b0, 12'h5A3);
    rd_b(1'b1, 12'h300);
    @(posedge clk);
    bus_b.nap_request_n <= 1'b0;
    tick(10);
    check(12'(nap_b), 12'h000);
    @(posedge clk);
    bus_b.convert_strobe_n <= 1'b0;
    wait_b(1'b1, 10);
    wait_b(1'b0, CONV_CYC);
    tick(3);
    check(12'(nap_b), 12'h001);
    @(posedge clk);
    bus_b.convert_strobe_n <= 1'b1;
    tick(6);
    check(12'(nap_b), 12'h000);
    bus_b.nap_request_n <= 1'b1;
    bus_b.convert_strobe_n <= 1'b0;
    wait_b(1'b1, 10);
    @(posedge clk);
    bus_b.convert_strobe_n <= 1'b1;
    bus_b.chip_select_n <= 1'b1;
    tick(4);
    bus_b.chip_select_n <= 1'b0;
    wait_b(1'b0, 12);
    check(12'(n < 12), 12'h001);
    rd_b(1'b0, CODE_ABORT);
    @(posedge clk);
    bus_b.convert_strobe_n <= 1'b0;
    wait_b(1'b1, 10);
    @(posedge clk);
    bus_b.powerdown_reset_n <= 1'b0;
    wait_b(1'b0, 12);
    check(12'(n < 12), 12'h001);
    rd_b(1'b0, CODE_ABORT);
    @(posedge clk);
    bus_b.powerdown_reset_n <= 1'b1;
    bus_b.convert_strobe_n <= 1'b1;
    tick(4);
    check(12'(pd_b), 12'h000);
    conv_b();
    check(12'(valid_b), 12'h000);
    bus_b.powerdown_reset_n <= 1'b0;
    tick(PD_ENTRY_CYC + 10);
    check(12'(pd_b), 12'h001);
    bus_b.powerdown_reset_n <= 1'b1;
    tick(PD_EXIT_CYC + 10);
    check(12'(pd_b), 12'h000);
    repeat (INIT_CONVERSIONS + 1) conv_b();
    check(12'(valid_b), 12'h001);
    end_sim();
  end
endmodule // tb
